// file: rtl/jtag_config_pkg.sv
// Constants and types shared by the serial configuration port
package jtag_config_pkg;

  localparam int IR_W    = 5;
  localparam int ID_W    = 32;
  localparam int USR_W   = 109;
  localparam int SIG_W   = 7;
  localparam int SIG_LSB = 100;
  localparam int LOCK_POS = 108;

  // Instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST   = 5'h00;
  localparam logic [IR_W-1:0] INS_ADDR_USR = 5'h01;
  localparam logic [IR_W-1:0] INS_ERASE    = 5'h02;
  localparam logic [IR_W-1:0] INS_VERIFY   = 5'h03;
  localparam logic [IR_W-1:0] INS_PROGRAM  = 5'h04;
  localparam logic [IR_W-1:0] INS_IDCODE   = 5'h0d;
  localparam logic [IR_W-1:0] INS_SAMPLE   = 5'h1e;
  localparam logic [IR_W-1:0] INS_BYPASS   = 5'h1f;

  // Identification word; value is arbitrary, bit 0 set as the scan standard asks
  localparam logic [ID_W-1:0] ID_WORD_DEF = 32'h0a5c_3001;

  localparam logic [USR_W-1:0] USR_ZERO = {USR_W{1'b0}};
  localparam logic             BYP_CAPT = 1'b0;

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_ERASE,
    OP_VERIFY
  } nv_op_t;

  typedef enum logic [1:0] {
    SEL_BYPASS,
    SEL_IDENT,
    SEL_USER
  } dr_sel_t;

  typedef enum {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // Scan pins driven by the programmer
  typedef struct packed {
    logic tms;
    logic tdi;
  } scan_in_t;

  // Scan output pin as data and enable
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } scan_out_t;

endpackage

// file: rtl/jtag_config_tap.sv
// Serial configuration test access port with nonvolatile configuration store
`timescale 1ns/10ps

module jtag_config_tap
  import jtag_config_pkg::*;
#(
  parameter logic [jtag_config_pkg::ID_W-1:0] ID_WORD = jtag_config_pkg::ID_WORD_DEF
) (
  // System clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            sys_rst,
  // Scan link
  input  wire logic                            tck,
  input  wire jtag_config_pkg::scan_in_t       scan_in,
  output jtag_config_pkg::scan_out_t           scan_out,
  // Configuration to the analog core
  output logic [jtag_config_pkg::USR_W-1:0]    cfg_bits,
  output logic [jtag_config_pkg::SIG_W-1:0]    user_signature_bits,
  output logic                                 security_lock_bit,
  output logic                                 nv_busy
);
  import jtag_config_pkg::*;

  // ---------------- TCK domain ----------------
  tap_state_t           state_ff;
  tap_state_t           nxt_state;
  logic                 trst_s1_ff;
  logic                 trst_s2_ff;
  logic [IR_W-1:0]      ir_sr_ff;
  logic [IR_W-1:0]      ir_ff;
  logic                 byp_ff;
  logic [ID_W-1:0]      id_sr_ff;
  logic [USR_W-1:0]     usr_sr_ff;
  logic                 req_ff;
  nv_op_t               op_ff;
  logic                 ack_s1_ff;
  logic                 ack_s2_ff;
  scan_out_t            out_ff;

  // ---------------- ref_clk domain ----------------
  logic                 req_s1_ff;
  logic                 req_s2_ff;
  logic                 req_s3_ff;
  logic                 ack_ff;
  logic [USR_W-1:0]     nv_ff;
  logic [USR_W-1:0]     vfy_ff;
  logic                 busy_ff;

  wire tms = scan_in.tms;
  wire tdi = scan_in.tdi;

  always_comb begin
    case (state_ff)
      ST_RESET:    nxt_state = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     nxt_state = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   nxt_state = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   nxt_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nxt_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nxt_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: nxt_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nxt_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   nxt_state = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   nxt_state = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   nxt_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nxt_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nxt_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: nxt_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nxt_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   nxt_state = tms ? ST_SEL_DR   : ST_IDLE;
      default:     nxt_state = ST_RESET;
    endcase
  end

  // Reset crossing into TCK: TCK may idle, so reset lands on the next edges
  always_ff @(posedge tck) begin
    trst_s1_ff <= sys_rst;
    trst_s2_ff <= trst_s1_ff;
  end

  wire tap_rst = trst_s2_ff;

  // power-on state; TMS high walks to reset in five edges at most
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // instruction decode, boundary codes fall to bypass
  function automatic dr_sel_t decode_sel(input logic [IR_W-1:0] ins);
    case (ins)
      INS_IDCODE:   decode_sel = SEL_IDENT;
      INS_ADDR_USR: decode_sel = SEL_USER;
      INS_PROGRAM:  decode_sel = SEL_USER;
      INS_ERASE:    decode_sel = SEL_USER;
      INS_VERIFY:   decode_sel = SEL_USER;
      default:      decode_sel = SEL_BYPASS;
    endcase
  endfunction

  wire dr_sel_t dr_sel     = decode_sel(ir_ff);
  wire          in_cap_dr  = (state_ff == ST_CAP_DR);
  wire          in_sh_dr   = (state_ff == ST_SHIFT_DR);
  wire          in_cap_ir  = (state_ff == ST_CAP_IR);
  wire          in_sh_ir   = (state_ff == ST_SHIFT_IR);
  wire          nv_pending = (req_ff != ack_s2_ff);
  wire          idle_entry = (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
  // Update-IR loads the register on the very edge that enters idle, so the
  // shifted code is looked at directly there, else that first entry is missed
  wire [IR_W-1:0] ins_now  = (state_ff == ST_UPD_IR) ? ir_sr_ff : ir_ff;
  wire          is_nv_ins  = (ins_now == INS_PROGRAM) || (ins_now == INS_ERASE) ||
                             (ins_now == INS_VERIFY);
  // idle only acts when a loaded instruction asks for it
  wire          start_op   = idle_entry && is_nv_ins && !nv_pending && !tap_rst;
  wire nv_op_t  op_code    = (ins_now == INS_PROGRAM) ? OP_PROGRAM :
                             (ins_now == INS_ERASE)   ? OP_ERASE : OP_VERIFY;

  // five-bit instruction shifter; pause leaves it alone
  always_ff @(posedge tck) begin
    if (in_cap_ir) begin
      ir_sr_ff <= INS_IDCODE;
    end else if (in_sh_ir) begin
      ir_sr_ff <= {tdi, ir_sr_ff[IR_W-1:1]};
    end
  end

  // instruction takes effect in Update-IR; reset selects identification
  always_ff @(posedge tck) begin
    if (tap_rst || state_ff == ST_RESET) begin
      ir_ff <= INS_IDCODE;
    end else if (state_ff == ST_UPD_IR) begin
      ir_ff <= ir_sr_ff;
    end
  end

  always_ff @(posedge tck) begin
    if (in_cap_dr && dr_sel == SEL_BYPASS) begin
      byp_ff <= BYP_CAPT;
    end else if (in_sh_dr && dr_sel == SEL_BYPASS) begin
      byp_ff <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (in_cap_dr && dr_sel == SEL_IDENT) begin
      id_sr_ff <= ID_WORD;
    end else if (in_sh_dr && dr_sel == SEL_IDENT) begin
      id_sr_ff <= {tdi, id_sr_ff[ID_W-1:1]};
    end
  end

  // user register; capture reads the verify copy once the
  // store has answered, else the shifted image is kept for a later program
  always_ff @(posedge tck) begin
    if (in_cap_dr && dr_sel == SEL_USER && !nv_pending) begin
      usr_sr_ff <= vfy_ff;
    end else if (in_sh_dr && dr_sel == SEL_USER) begin
      usr_sr_ff <= {tdi, usr_sr_ff[USR_W-1:1]};
    end
  end

  // request toggle; op code stays still while pending, the shifter only skips its capture
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      req_ff <= 1'b0;
      op_ff  <= OP_VERIFY;
    end else if (start_op) begin
      req_ff <= ~req_ff;
      op_ff  <= op_code;
    end
  end

  always_ff @(posedge tck) begin
    ack_s1_ff <= ack_ff;
    ack_s2_ff <= ack_s1_ff;
  end

  // serial output follows the selected path
  wire ser_out = in_sh_ir               ? ir_sr_ff[0]  :
                 (dr_sel == SEL_IDENT)  ? id_sr_ff[0]  :
                 (dr_sel == SEL_USER)   ? usr_sr_ff[0] : byp_ff;

  // TDO changes on the falling edge; enable only while shifting
  always_ff @(negedge tck) begin
    if (tap_rst) begin
      out_ff <= '0;
    end else begin
      out_ff.tdo    <= (in_sh_dr || in_sh_ir) ? ser_out : 1'b0;
      out_ff.tdo_oe <= in_sh_dr || in_sh_ir;
    end
  end

  assign scan_out = out_ff;

  // ---------------- Nonvolatile store on ref_clk ----------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  wire nv_go = req_s2_ff ^ req_s3_ff;

  // Cells only program from zero to one, so a full rewrite needs an erase first;
  // contents survive sys_rst as nonvolatile cells would
  always_ff @(posedge ref_clk) begin
    if (nv_go && op_ff == OP_PROGRAM) begin
      nv_ff <= nv_ff | usr_sr_ff;
    end else if (nv_go && op_ff == OP_ERASE) begin
      nv_ff <= USR_ZERO;
    end
  end

  // verify under lock reads back zeros
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vfy_ff <= USR_ZERO;
    end else if (nv_go && op_ff == OP_VERIFY) begin
      vfy_ff <= nv_ff[LOCK_POS] ? USR_ZERO : nv_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_ff  <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      ack_ff  <= req_s2_ff;
      busy_ff <= nv_go;
    end
  end

  assign cfg_bits            = nv_ff;
  // signature field of the stored configuration
  assign user_signature_bits = nv_ff[SIG_LSB +: SIG_W];
  assign security_lock_bit   = nv_ff[LOCK_POS];
  assign nv_busy             = busy_ff;

endmodule

// file: tb/jtag_config_tap_chk.sv
// Port checker for the scan configuration block
`timescale 1ns/10ps
module jtag_config_tap_chk (
  // System side
  input wire logic                               ref_clk,
  input wire logic                               sys_rst,
  // Scan link
  input wire logic                               tck,
  input wire jtag_config_pkg::scan_in_t          scan_in,
  input wire jtag_config_pkg::scan_out_t         scan_out,
  // Stored configuration
  input wire logic [jtag_config_pkg::USR_W-1:0]  cfg_bits,
  input wire logic [jtag_config_pkg::SIG_W-1:0]  user_signature_bits,
  input wire logic                               security_lock_bit,
  input wire logic                               nv_busy
);
  import jtag_config_pkg::*;
  sequence tms_high5;
    scan_in.tms [*5];
  endsequence
  a_sig_mirror: assert property (@(posedge ref_clk) disable iff (sys_rst)
    nv_busy |-> user_signature_bits == cfg_bits[SIG_LSB+SIG_W-1:SIG_LSB]) else $error("sig");
  a_lock_mirror: assert property (@(posedge ref_clk) disable iff (sys_rst)
    nv_busy |-> security_lock_bit == cfg_bits[LOCK_POS]) else $error("lock");
  a_busy_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    nv_busy |=> !nv_busy) else $error("busy width");
  // store changes only with an operation
  a_cfg_then_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(cfg_bits) |-> nv_busy) else $error("cfg changed alone");
  a_oe_idle: assert property (@(posedge tck) disable iff (sys_rst)
    !scan_out.tdo_oe |-> !scan_out.tdo) else $error("tdo off");
  // high mode select always leaves shift
  a_exit_shift: assert property (@(posedge tck) disable iff (sys_rst)
    scan_in.tms |=> !scan_out.tdo_oe) else $error("shift kept");
  // shift entered only on a low mode select
  a_oe_entry: assert property (@(posedge tck) disable iff (sys_rst)
    $rose(scan_out.tdo_oe) |-> $past(scan_in.tms) == 1'b0) else $error("shift entry");
  // low mode select stays in shift
  a_oe_hold: assert property (@(posedge tck) disable iff (sys_rst)
    scan_out.tdo_oe && !scan_in.tms |=> scan_out.tdo_oe) else $error("shift lost");
  // five high cycles park the port
  a_tms_reset: assert property (@(posedge tck) disable iff (sys_rst)
    tms_high5 |=> !scan_out.tdo_oe [*2]) else $error("no park");
endmodule
bind jtag_config_tap jtag_config_tap_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .tck(tck), .scan_in(scan_in), .scan_out(scan_out), .cfg_bits(cfg_bits),
  .user_signature_bits(user_signature_bits), .security_lock_bit(security_lock_bit),
  .nv_busy(nv_busy));

// file: tb/scan_host.sv
// Programmer model; its clock runs only while it steps
`timescale 1ns/10ps
module scan_host (
  // Scan pins
  output logic                            tck,
  output jtag_config_pkg::scan_in_t       scan_in,
  input  wire jtag_config_pkg::scan_out_t scan_out
);
  import jtag_config_pkg::*;
  logic got;
  logic got_bit;
  initial begin
    tck = 1'b0;
    scan_in = '0;
    got = 1'b0;
    got_bit = 1'b0;
  end
  // pins change with clock low, output taken at the rise
  task automatic step(input logic t, input logic d, input logic look);
    scan_in = '{tms: t, tdi: d};
    #3 tck = 1'b1;
    got_bit = scan_out.tdo;
    got = look;
    #3 tck = 1'b0;
    got = 1'b0;
  endtask
endmodule

// file: tb/jtag_config_tap_bench.sv
// Self-checking bench for the scan configuration block
`timescale 1ns/10ps
module jtag_config_tap_bench;
  import jtag_config_pkg::*;
  logic             ref_clk;
  logic             sys_rst;
  logic             tck;
  scan_in_t         scan_in;
  scan_out_t        scan_out;
  logic [USR_W-1:0] cfg_bits;
  logic [SIG_W-1:0] sig;
  logic             lock;
  logic             nv_busy;
  logic [1:0]       bit_q[$];
  logic [USR_W-1:0] cfg_q[$];
  logic [USR_W-1:0] ud;
  logic [USR_W-1:0] e;
  logic [1:0]       b;
  logic [IR_W-1:0]  byp [4] = '{INS_EXTEST, INS_SAMPLE, INS_BYPASS, 5'h10};
  integer           seed;
  int               fails, compares, cyc, i;
  jtag_config_tap dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .scan_in(scan_in),
    .scan_out(scan_out), .cfg_bits(cfg_bits), .user_signature_bits(sig),
    .security_lock_bit(lock), .nv_busy(nv_busy));
  scan_host host (.tck(tck), .scan_in(scan_in), .scan_out(scan_out));
  always #5 ref_clk = ~ref_clk;
  function automatic logic [USR_W-1:0] rnd();
    rnd = USR_W'({$random(seed), $random(seed), $random(seed), $random(seed)});
  endfunction
  task automatic walk(input logic [31:0] t, input int n);
    for (int k = 0; k < n; k++) begin
      host.step(t[k], 1'b0, 1'b0);
    end
  endtask
  // Scan from idle back to idle; pz picks a bit after which to pause
  task automatic scan(input logic ir, input int n, input logic [USR_W-1:0] d,
                      input logic [USR_W-1:0] x, input logic [USR_W-1:0] c, input int pz);
    walk(ir ? 32'h3 : 32'h1, ir ? 4 : 3);
    for (int k = 0; k < n; k++) begin
      bit_q.push_back({c[k], x[k]});
      host.step(k == n - 1 || k == pz, d[k], 1'b1);
      // pause holds the shifter, then resume
      if (k == pz && k != n - 1) walk(32'h4, 4);
    end
    walk(32'h1, 2);
  endtask
  // every instruction load shifts out the identification code
  task automatic ir_load(input logic [IR_W-1:0] code);
    scan(1'b1, IR_W, USR_W'(code), USR_W'(INS_IDCODE), USR_W'(5'h1f), -1);
  endtask
  task automatic op(input logic [IR_W-1:0] code, input logic p, input logic [USR_W-1:0] x);
    if (p) cfg_q.push_back(x);
    ir_load(code);
    walk(32'h0, 20);
  endtask
  task automatic end_of_test();
    if (cfg_q.size() != 0 || bit_q.size() != 0) begin
      $display("BAD %0t results never seen", $time);
      fails++;
    end
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge host.got) begin
    b = bit_q.pop_front();
    if (b[1]) begin
      compares++;
      if (host.got_bit !== b[0]) begin
        $display("BAD %0t serial bit", $time);
        fails++;
      end
    end
  end
  always @(posedge ref_clk) begin
    if (nv_busy === 1'b1 && cfg_q.size() > 0) begin
      e = cfg_q.pop_front();
      compares++;
      if (cfg_bits !== e || sig !== e[SIG_LSB +: SIG_W] || lock !== e[LOCK_POS]) begin
        $display("BAD %0t stored bits", $time);
        fails++;
      end
    end
  end
  // Whole run is under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    seed = 85;
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    // reset held while the scan clock runs
    repeat (5) walk(32'hff, 8);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    walk(32'h7f, 8);
    scan(1'b0, ID_W, rnd(), USR_W'(ID_WORD_DEF), USR_W'(32'hffff_ffff), -1);
    for (i = 0; i < 4; i++) begin
      ud = rnd();
      ir_load(byp[i]);
      scan(1'b0, 16, ud, ud << 1, USR_W'(16'hffff), i);
    end
    // erase, load the user register, program
    op(INS_ERASE, 1'b1, '0);
    ud = rnd();
    ud[LOCK_POS] = 1'b0;
    ir_load(INS_ADDR_USR);
    scan(1'b0, USR_W, ud, '0, '0, -1);
    op(INS_PROGRAM, 1'b1, ud);
    op(INS_VERIFY, 1'b0, '0);
    ir_load(INS_ADDR_USR);
    scan(1'b0, USR_W, USR_W'(1) << LOCK_POS, ud, '1, -1);
    op(INS_PROGRAM, 1'b1, ud | (USR_W'(1) << LOCK_POS));
    op(INS_VERIFY, 1'b0, '0);
    ir_load(INS_ADDR_USR);
    scan(1'b0, USR_W, ud, '0, '1, -1);
    op(INS_ERASE, 1'b1, '0);
    // five high cycles from shift restore the identification path
    walk(32'h1, 3);
    walk(32'h1f, 6);
    scan(1'b0, ID_W, rnd(), USR_W'(ID_WORD_DEF), USR_W'(32'hffff_ffff), -1);
    end_of_test();
  end
endmodule
